/* File: src/dfb_pkg.sv */
package dfb_pkg;
    // ----------------------------------------
    // parameter addresses
    // ----------------------------------------
    localparam logic [15:0] ADR_ACK_MIN = 16'h0648;
    localparam logic [15:0] ADR_RATE = 16'h1606;
    localparam logic [15:0] ADR_STN = 16'h1608;
    localparam logic [15:0] ADR_FMT = 16'h160a;
    localparam logic [15:0] ADR_GUARD = 16'h160c;
    localparam logic [15:0] ADR_SORD = 16'h160e;
    localparam logic [15:0] ADR_FWUP = 16'h1618;
    localparam logic [15:0] ADR_TORD = 16'h190a;
    localparam logic [15:0] ADR_MFC = 16'h1b32;

    // ----------------------------------------
    // factory values
    // ----------------------------------------
    localparam logic [15:0] RST_ACK_MIN = 16'h0000;
    localparam logic [15:0] RST_RATE = 16'h4b00;
    localparam logic [7:0] RST_STN = 8'h01;
    localparam logic [2:0] RST_FMT = 3'h2;
    localparam logic [15:0] RST_GUARD = 16'h0000;
    localparam logic RST_ORD = 1'b0;
    localparam logic RST_FWUP = 1'b0;
    localparam logic [15:0] RST_MFC = 16'h0000;

    // ----------------------------------------
    // legal values
    // ----------------------------------------
    localparam logic [15:0] STN_MIN = 16'h0001;
    localparam logic [15:0] STN_MAX = 16'h00f7;
    localparam logic [15:0] RATE_9600 = 16'h2580;
    localparam logic [15:0] RATE_19200 = 16'h4b00;
    localparam logic [15:0] RATE_38400 = 16'h9600;
    localparam logic [15:0] FMT_8N1 = 16'h0001;
    localparam logic [15:0] FMT_8E1 = 16'h0002;
    localparam logic [15:0] FMT_8O1 = 16'h0003;
    localparam logic [15:0] FMT_8N2 = 16'h0004;
    localparam logic [15:0] BIT_MAX = 16'h0001;
    localparam logic [15:0] GUARD_MAX = 16'h2710;
    localparam logic [15:0] ACK_MIN_MAX = 16'h3fff;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int MS_TIME_NS = 1000000;
    localparam int CLK_PERIOD_NS = 5;
    localparam int CYC_PER_MS_DEF = MS_TIME_NS / CLK_PERIOD_NS;
    localparam int ACK_CHANNELS = 3;

    typedef enum logic [1:0] {ACK_IDLE, ACK_MOVE, ACK_HOLD} dfb_ack_state_t;
endpackage

/* File: src/dfb_ack_stretch.sv */
`timescale 1ns/10ps
`default_nettype none
module dfb_ack_stretch import dfb_pkg::*; (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // timing and setting
    input wire logic ms_tick,
    input wire logic [15:0] min_time,
    // movement
    input wire logic busy,
    output logic ack
);
    dfb_ack_state_t state_reg, state_next;
    logic [15:0] cnt_reg;
    logic ack_reg;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    wire cnt_done = cnt_reg > min_time;
    wire no_min = min_time == 16'h0000;

    // movement tracking with low-time extension
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ACK_IDLE: begin
                if (busy) state_next = ACK_MOVE;
            end
            ACK_MOVE: begin
                if (!busy) state_next = (no_min || cnt_done) ? ACK_IDLE : ACK_HOLD; // RULE9
            end
            ACK_HOLD: begin
                if (busy) state_next = ACK_MOVE;
                else if (cnt_done) state_next = ACK_IDLE; // RULE10
            end
            default: state_next = ACK_IDLE;
        endcase
    end

    // state, ms counter and ack bit
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg <= ACK_IDLE;
            cnt_reg <= 16'h0000;
            ack_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            if (state_reg == ACK_IDLE) cnt_reg <= 16'h0000;
            else if (ms_tick && cnt_reg != 16'hffff) cnt_reg <= cnt_reg + 16'h0001;
            ack_reg <= state_next == ACK_IDLE; // RULE11
        end
    end

    assign ack = ack_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_short_end;
        state_reg == ACK_MOVE && !busy && !no_min && !cnt_done;
    endsequence
    sequence s_hold_over;
        state_reg == ACK_HOLD && !busy && cnt_done;
    endsequence

    property p_busy_low;
        busy |=> !ack;
    endproperty
    a_busy_low: assert property (p_busy_low) else $error("ack high during move"); // RULE9
    property p_zero_min;
        state_reg == ACK_MOVE && !busy && no_min |=> ack;
    endproperty
    a_zero_min: assert property (p_zero_min) else $error("ack late with zero min"); // RULE9
    property p_short_hold;
        s_short_end |=> !ack && state_reg == ACK_HOLD;
    endproperty
    a_short_hold: assert property (p_short_hold) else $error("short move not held"); // RULE10
    property p_hold_release;
        s_hold_over |=> ack;
    endproperty
    a_hold_release: assert property (p_hold_release) else $error("hold not ended"); // RULE10
    property p_long_move;
        state_reg == ACK_MOVE && !busy && cnt_done |=> ack;
    endproperty
    a_long_move: assert property (p_long_move) else $error("long move extended"); // RULE11
endmodule
`default_nettype wire

/* File: src/dfb_param_bank.sv */
// Operation
// RULE1 - station address 1..247, applied at once
// RULE2 - rate 9600/19200/38400, applied at power-up
// RULE3 - serial word order 0 high first, immediate
// RULE4 - char format codes 1..4, applied at power-up
// RULE5 - supervision zero off, else ms up to 10000
// RULE6 - tcp update gate, written only over rtu
// RULE7 - master clears update gate after update
// RULE8 - tcp word order, applied at power-up
// RULE9 - zero minimum: ack follows movement only
// RULE10 - short move keeps ack low minimum time
// RULE11 - long move: ack from movement only
// RULE12 - same minimum for reference and homing bits
// RULE13 - minimum locked while power stage enabled
// RULE14 - read-only mode fault cause code
// RULE15 - no request within time raises fault
`timescale 1ns/10ps
`default_nettype none
module dfb_param_bank import dfb_pkg::*; #(
    parameter int CYC_PER_MS = CYC_PER_MS_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic arst_n,
    // parameter access
    input wire logic par_wr,
    input wire logic par_rd,
    input wire logic [15:0] par_addr,
    input wire logic [15:0] par_wdata,
    input wire logic par_from_rtu,
    output logic [15:0] par_rdata,
    output logic par_ack,
    output logic par_reject,
    // drive events
    input wire logic power_up_load,
    input wire logic power_stage_en,
    input wire logic master_req_valid,
    input wire logic mode_fault_set,
    input wire logic [15:0] mode_fault_code,
    input wire logic [2:0] move_busy,
    // active settings
    output logic [7:0] station_addr,
    output logic [15:0] serial_rate,
    output logic fmt_parity_en,
    output logic fmt_parity_odd,
    output logic fmt_two_stop,
    output logic serial_low_word_first,
    output logic tcp_low_word_first,
    output logic tcp_fw_update_allow,
    // status
    output logic comm_fault,
    output logic mode_fault_flag,
    output logic [2:0] ack_bits
);
    localparam int MS_W = $clog2(CYC_PER_MS + 1);
    localparam logic [MS_W-1:0] MS_LAST = MS_W'(CYC_PER_MS - 1);

    logic [15:0] ack_min_reg, rate_reg, rate_act_reg, guard_reg, mfc_reg;
    logic [15:0] sup_cnt_reg, rdata_reg, rd_mux;
    logic [7:0] stn_reg;
    logic [2:0] fmt_reg, fmt_act_reg;
    logic sord_reg, fw_reg, tord_reg, tord_act_reg, mf_flag_reg, fault_reg;
    logic ack_reg, reject_reg, par_en_reg, par_odd_reg, two_stop_reg, ms_tick_reg;
    logic [MS_W-1:0] ms_cnt_reg;

    // ----------------------------------------
    // address decode and value checks
    // ----------------------------------------
    wire hit_ack = par_addr == ADR_ACK_MIN;
    wire hit_rate = par_addr == ADR_RATE;
    wire hit_stn = par_addr == ADR_STN;
    wire hit_fmt = par_addr == ADR_FMT;
    wire hit_guard = par_addr == ADR_GUARD;
    wire hit_sord = par_addr == ADR_SORD;
    wire hit_fw = par_addr == ADR_FWUP;
    wire hit_tord = par_addr == ADR_TORD;
    wire hit_mfc = par_addr == ADR_MFC;
    wire stn_ok = par_wdata >= STN_MIN && par_wdata <= STN_MAX; // RULE1
    wire rate_ok = par_wdata == RATE_9600 || par_wdata == RATE_19200
        || par_wdata == RATE_38400; // RULE2
    wire fmt_ok = par_wdata >= FMT_8N1 && par_wdata <= FMT_8N2; // RULE4
    wire bit_ok = par_wdata <= BIT_MAX;
    wire guard_ok = par_wdata <= GUARD_MAX; // RULE5
    wire ackm_ok = par_wdata <= ACK_MIN_MAX && !power_stage_en; // RULE13
    wire fw_ok = bit_ok && par_from_rtu; // RULE6

    // writes that pass the checks; the cause code takes none
    wire wr_legal = (hit_ack && ackm_ok) || (hit_rate && rate_ok) || (hit_stn && stn_ok)
        || (hit_fmt && fmt_ok) || (hit_guard && guard_ok) || (hit_sord && bit_ok)
        || (hit_fw && fw_ok) || (hit_tord && bit_ok); // RULE14
    wire rd_legal = hit_ack || hit_rate || hit_stn || hit_fmt || hit_guard || hit_sord
        || hit_fw || hit_tord || hit_mfc;
    wire req = par_wr || par_rd;
    wire req_ok = par_wr ? wr_legal : rd_legal;
    wire wr_go = par_wr && wr_legal;
    wire rd_go = !par_wr && par_rd && rd_legal;

    // format decode of the pending code
    wire fmt_par_en = fmt_reg == FMT_8E1[2:0] || fmt_reg == FMT_8O1[2:0]; // RULE4
    wire fmt_odd = fmt_reg == FMT_8O1[2:0];
    wire fmt_2stop = fmt_reg == FMT_8N2[2:0];

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        case (1'b1)
            hit_ack: rd_mux = ack_min_reg;
            hit_rate: rd_mux = rate_reg;
            hit_stn: rd_mux = {8'h00, stn_reg};
            hit_fmt: rd_mux = {13'h0000, fmt_reg};
            hit_guard: rd_mux = guard_reg;
            hit_sord: rd_mux = {15'h0000, sord_reg};
            hit_fw: rd_mux = {15'h0000, fw_reg};
            hit_tord: rd_mux = {15'h0000, tord_reg};
            hit_mfc: rd_mux = mfc_reg;
            default: rd_mux = 16'h0000;
        endcase
    end

    // answer one cycle after the request
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg <= 1'b0;
            reject_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            ack_reg <= req;
            reject_reg <= req && !req_ok;
            if (rd_go) rdata_reg <= rd_mux;
        end
    end

    // ----------------------------------------
    // stored settings
    // ----------------------------------------
    // immediate settings
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            stn_reg <= RST_STN;
            sord_reg <= RST_ORD;
            guard_reg <= RST_GUARD;
            fw_reg <= RST_FWUP;
            ack_min_reg <= RST_ACK_MIN;
        end else if (wr_go) begin
            if (hit_stn) stn_reg <= par_wdata[7:0]; // RULE1
            if (hit_sord) sord_reg <= par_wdata[0]; // RULE3
            if (hit_guard) guard_reg <= par_wdata; // RULE5
            if (hit_fw) fw_reg <= par_wdata[0]; // RULE6
            if (hit_ack) ack_min_reg <= par_wdata; // RULE13
        end
    end

    // settings held pending until power-up
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_reg <= RST_RATE;
            fmt_reg <= RST_FMT;
            tord_reg <= RST_ORD;
        end else if (wr_go) begin
            if (hit_rate) rate_reg <= par_wdata;
            if (hit_fmt) fmt_reg <= par_wdata[2:0];
            if (hit_tord) tord_reg <= par_wdata[0];
        end
    end

    // active copies taken at power-up
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rate_act_reg <= RST_RATE;
            fmt_act_reg <= RST_FMT;
            tord_act_reg <= RST_ORD;
            par_en_reg <= 1'b1;
            par_odd_reg <= 1'b0;
            two_stop_reg <= 1'b0;
        end else if (power_up_load) begin
            rate_act_reg <= rate_reg; // RULE2
            fmt_act_reg <= fmt_reg; // RULE4
            par_en_reg <= fmt_par_en;
            par_odd_reg <= fmt_odd;
            two_stop_reg <= fmt_2stop;
            tord_act_reg <= tord_reg; // RULE8
        end
    end

    // ----------------------------------------
    // mode fault cause
    // ----------------------------------------
    // code latched with the flag; a read clears the flag, a new fault wins
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mfc_reg <= RST_MFC;
            mf_flag_reg <= 1'b0;
        end else begin
            if (mode_fault_set) mfc_reg <= mode_fault_code; // RULE14
            if (mode_fault_set) mf_flag_reg <= 1'b1;
            else if (rd_go && hit_mfc) mf_flag_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // ms tick and link supervision
    // ----------------------------------------
    wire sup_on = guard_reg != 16'h0000;
    wire sup_expire = sup_on && ms_tick_reg && sup_cnt_reg >= guard_reg - 16'h0001;

    // free-running millisecond prescaler
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ms_cnt_reg <= '0;
            ms_tick_reg <= 1'b0;
        end else begin
            ms_tick_reg <= ms_cnt_reg == MS_LAST;
            ms_cnt_reg <= (ms_cnt_reg == MS_LAST) ? '0 : ms_cnt_reg + 1'b1;
        end
    end

    // timer restarts on every request; expiry wins over a clear
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            sup_cnt_reg <= 16'h0000;
            fault_reg <= 1'b0;
        end else begin
            if (!sup_on || master_req_valid) sup_cnt_reg <= 16'h0000; // RULE15
            else if (ms_tick_reg && sup_cnt_reg < guard_reg) sup_cnt_reg <= sup_cnt_reg + 16'h0001;
            if (sup_expire) fault_reg <= 1'b1; // RULE15
            else if (!sup_on || master_req_valid) fault_reg <= 1'b0; // RULE5
        end
    end

    // ----------------------------------------
    // acknowledge bits: motion, reference done, homing
    // ----------------------------------------
    for (genvar i = 0; i < ACK_CHANNELS; i++) begin : g_ack
        dfb_ack_stretch u_ack (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .ms_tick(ms_tick_reg),
            .min_time(ack_min_reg), // RULE12
            .busy(move_busy[i]),
            .ack(ack_bits[i])
        );
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign par_rdata = rdata_reg;
    assign par_ack = ack_reg;
    assign par_reject = reject_reg;
    assign station_addr = stn_reg;
    assign serial_rate = rate_act_reg;
    assign fmt_parity_en = par_en_reg;
    assign fmt_parity_odd = par_odd_reg;
    assign fmt_two_stop = two_stop_reg;
    assign serial_low_word_first = sord_reg;
    assign tcp_low_word_first = tord_act_reg;
    assign tcp_fw_update_allow = fw_reg;
    assign comm_fault = fault_reg;
    assign mode_fault_flag = mf_flag_reg;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    property p_stn_now;
        wr_go && hit_stn |=> station_addr == $past(par_wdata[7:0]);
    endproperty
    a_stn_now: assert property (p_stn_now) else $error("station address not applied"); // RULE1
    property p_stn_range;
        par_wr && hit_stn && !stn_ok |=> $stable(station_addr) && par_reject;
    endproperty
    a_stn_range: assert property (p_stn_range) else $error("bad station address taken"); // RULE1
    property p_rate_defer;
        !power_up_load |=> $stable(serial_rate);
    endproperty
    a_rate_defer: assert property (p_rate_defer) else $error("rate changed early"); // RULE2
    property p_sord_now;
        wr_go && hit_sord |=> serial_low_word_first == $past(par_wdata[0]);
    endproperty
    a_sord_now: assert property (p_sord_now) else $error("serial order not applied"); // RULE3
    property p_fmt_odd;
        power_up_load && fmt_reg == FMT_8O1[2:0] |=> fmt_parity_en && fmt_parity_odd
            && !fmt_two_stop;
    endproperty
    a_fmt_odd: assert property (p_fmt_odd) else $error("odd format decode"); // RULE4
    property p_guard_off;
        !sup_on |=> !comm_fault;
    endproperty
    a_guard_off: assert property (p_guard_off) else $error("fault with supervision off"); // RULE5
    property p_fw_rtu;
        par_wr && hit_fw && !par_from_rtu |=> $stable(tcp_fw_update_allow) && par_reject;
    endproperty
    a_fw_rtu: assert property (p_fw_rtu) else $error("update gate written off rtu"); // RULE6
    property p_tord_defer;
        !power_up_load |=> $stable(tcp_low_word_first);
    endproperty
    a_tord_defer: assert property (p_tord_defer) else $error("tcp order changed early"); // RULE8
    property p_ackmin_lock;
        par_wr && hit_ack && power_stage_en |=> $stable(ack_min_reg) && par_reject;
    endproperty
    a_ackmin_lock: assert property (p_ackmin_lock) else $error("min time written live"); // RULE13
    property p_mfc_ro;
        par_wr && hit_mfc |=> par_reject;
    endproperty
    a_mfc_ro: assert property (p_mfc_ro) else $error("cause code write accepted"); // RULE14
    property p_sup_fault;
        sup_expire |=> comm_fault;
    endproperty
    a_sup_fault: assert property (p_sup_fault) else $error("supervision fault missed"); // RULE15
    property p_req_clear;
        sup_on && master_req_valid && !sup_expire |=> !comm_fault ##0 sup_cnt_reg == 16'h0000;
    endproperty
    a_req_clear: assert property (p_req_clear) else $error("request did not restart"); // RULE15
endmodule
`default_nettype wire

/* File: verification/dfb_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dfb_master_model import dfb_pkg::*; (
    // clock
    input wire logic sys_clk,
    // requests
    output logic par_wr,
    output logic par_rd,
    output logic [15:0] par_addr,
    output logic [15:0] par_wdata,
    output logic par_from_rtu,
    output logic master_req_valid,
    // answers
    input wire logic [15:0] par_rdata,
    input wire logic par_ack,
    input wire logic par_reject
);
    int idle_cyc = 0;

    // idle bus at time zero
    initial begin
        {par_wr, par_rd, par_from_rtu, master_req_valid} = 4'h0;
        {par_addr, par_wdata} = 32'h0;
    end

    // one request pulse; the answer must stand on the next cycle
    task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                        input logic rtu, output logic [15:0] rd, output logic rj);
        repeat (idle_cyc + 1) @(negedge sys_clk);
        par_wr = w;
        par_rd = !w;
        par_addr = a;
        par_wdata = d;
        par_from_rtu = rtu;
        master_req_valid = 1'b1;
        @(negedge sys_clk);
        par_wr = 1'b0;
        par_rd = 1'b0;
        master_req_valid = 1'b0;
        par_addr = ~a; // released bus shows no stale value
        par_wdata = ~d;
        par_from_rtu = ~rtu;
        rd = par_rdata;
        rj = (par_ack === 1'b1) ? par_reject : 1'bx;
    endtask

    // close the update gate once an update is over
    task automatic fw_update_done(output logic rj);
        logic [15:0] rd;
        xfer(1'b1, ADR_FWUP, 16'h0000, 1'b1, rd, rj);
    endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_top import dfb_pkg::*;;
    localparam int CPM = 10;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic par_wr, par_rd, par_from_rtu, master_req_valid, par_ack, par_reject;
    logic [15:0] par_addr, par_wdata, par_rdata, serial_rate;
    logic power_up_load = 1'b0;
    logic power_stage_en = 1'b0;
    logic mode_fault_set = 1'b0;
    logic [15:0] mode_fault_code = 16'h0000;
    logic [2:0] move_busy = 3'h0;
    logic [7:0] station_addr;
    logic fmt_parity_en, fmt_parity_odd, fmt_two_stop, serial_low_word_first;
    logic tcp_low_word_first, tcp_fw_update_allow, comm_fault, mode_fault_flag;
    logic [2:0] ack_bits;
    int n_mismatch = 0;
    int compares = 0;
    int cyc = 0;

    dfb_param_bank #(.CYC_PER_MS(CPM)) u_dfb_param_bank (
        .sys_clk, .arst_n, .par_wr, .par_rd, .par_addr, .par_wdata, .par_from_rtu,
        .par_rdata, .par_ack, .par_reject, .power_up_load, .power_stage_en,
        .master_req_valid, .mode_fault_set, .mode_fault_code, .move_busy,
        .station_addr, .serial_rate, .fmt_parity_en, .fmt_parity_odd, .fmt_two_stop,
        .serial_low_word_first, .tcp_low_word_first, .tcp_fw_update_allow,
        .comm_fault, .mode_fault_flag, .ack_bits);

    dfb_master_model u_dfb_master_model (
        .sys_clk, .par_wr, .par_rd, .par_addr, .par_wdata, .par_from_rtu,
        .master_req_valid, .par_rdata, .par_ack, .par_reject);

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic complete_run();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask

    task automatic chkb(input logic got, input logic exp, input string m);
        chk({15'h0000, got}, {15'h0000, exp}, m);
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic rtu,
                      input logic rej);
        logic [15:0] v;
        logic rj;
        u_dfb_master_model.xfer(1'b1, a, d, rtu, v, rj);
        chkb(rj, rej, "write refusal");
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input logic rej);
        logic [15:0] v;
        logic rj;
        u_dfb_master_model.xfer(1'b0, a, 16'h0000, 1'b0, v, rj);
        chkb(rj, rej, "read refusal");
        if (!rej) chk(v, exp, "read value");
    endtask

    task automatic pulse_pu();
        @(negedge sys_clk);
        power_up_load = 1'b1;
        @(negedge sys_clk);
        power_up_load = 1'b0;
    endtask

    // move on the given bits, counting cycles from the move start until the first ack leaves its moving value
    task automatic move(input logic [2:0] b, input int len, output int low);
        @(negedge sys_clk);
        move_busy = b;
        repeat (len) @(negedge sys_clk);
        chk({13'h0000, ack_bits}, {13'h0000, ~b}, "ack low in move");
        move_busy = 3'h0;
        low = len;
        while (ack_bits === ~b && low < 80) begin
            @(negedge sys_clk);
            low++;
        end
        chk({13'h0000, ack_bits}, 16'h0007, "acks back together");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(ADR_ACK_MIN, 16'h0000, 1'b0);
        rd(ADR_RATE, 16'h4b00, 1'b0);
        rd(ADR_STN, 16'h0001, 1'b0);
        rd(ADR_FMT, 16'h0002, 1'b0);
        rd(ADR_GUARD, 16'h0000, 1'b0);
        rd(ADR_SORD, 16'h0000, 1'b0);
        rd(ADR_FWUP, 16'h0000, 1'b0);
        rd(ADR_TORD, 16'h0000, 1'b0);
        rd(ADR_MFC, 16'h0000, 1'b0);
        rd(16'h1600, 16'h0000, 1'b1);
        chk({13'h0000, ack_bits}, 16'h0007, "ack idle");
        $display("reset test done");
    endtask

    task automatic t_station();
        u_dfb_master_model.idle_cyc = 3;
        wr(ADR_STN, 16'h0000, 1'b0, 1'b1);
        wr(ADR_STN, 16'h00f8, 1'b0, 1'b1);
        chk({8'h00, station_addr}, 16'h0001, "address kept");
        wr(ADR_STN, 16'h00f7, 1'b0, 1'b0);
        chk({8'h00, station_addr}, 16'h00f7, "address at once");
        rd(ADR_STN, 16'h00f7, 1'b0);
        u_dfb_master_model.idle_cyc = 0;
        $display("station test done");
    endtask

    task automatic t_powerup();
        logic [15:0] rates [3] = '{16'h2580, 16'h9600, 16'h4b00};
        logic [2:0] fx [4] = '{3'h0, 3'h4, 3'h6, 3'h1};
        logic [15:0] prev;
        prev = 16'h4b00;
        foreach (rates[i]) begin
            wr(ADR_RATE, rates[i], 1'b0, 1'b0);
            chk(serial_rate, prev, "rate waits");
            pulse_pu();
            chk(serial_rate, rates[i], "rate at power-up");
            prev = rates[i];
        end
        wr(ADR_RATE, 16'h04b0, 1'b0, 1'b1);
        wr(ADR_FMT, 16'h0000, 1'b0, 1'b1);
        wr(ADR_FMT, 16'h0005, 1'b0, 1'b1);
        prev = 16'h0004;
        for (int k = 1; k <= 4; k++) begin
            wr(ADR_FMT, 16'(k), 1'b0, 1'b0);
            chk({13'h0000, fmt_parity_en, fmt_parity_odd, fmt_two_stop}, prev, "fmt waits");
            pulse_pu();
            prev = {13'h0000, fx[k-1]};
            chk({13'h0000, fmt_parity_en, fmt_parity_odd, fmt_two_stop}, prev, "fmt");
        end
        wr(ADR_TORD, 16'h0002, 1'b0, 1'b1);
        wr(ADR_TORD, 16'h0001, 1'b0, 1'b0);
        chkb(tcp_low_word_first, 1'b0, "tcp order waits");
        pulse_pu();
        chkb(tcp_low_word_first, 1'b1, "tcp order");
        $display("power-up test done");
    endtask

    task automatic t_order_fw();
        logic rj;
        wr(ADR_SORD, 16'h0001, 1'b0, 1'b0);
        chkb(serial_low_word_first, 1'b1, "serial order");
        wr(ADR_SORD, 16'h0002, 1'b0, 1'b1);
        wr(ADR_SORD, 16'h0000, 1'b0, 1'b0);
        chkb(serial_low_word_first, 1'b0, "serial order back");
        wr(ADR_FWUP, 16'h0001, 1'b0, 1'b1);
        chkb(tcp_fw_update_allow, 1'b0, "gate via tcp");
        wr(ADR_FWUP, 16'h0001, 1'b1, 1'b0);
        chkb(tcp_fw_update_allow, 1'b1, "gate open");
        u_dfb_master_model.fw_update_done(rj);
        chkb(rj, 1'b0, "gate close taken");
        chkb(tcp_fw_update_allow, 1'b0, "gate closed");
        $display("order test done");
    endtask

    task automatic t_guard();
        int n;
        wr(ADR_GUARD, 16'h2711, 1'b0, 1'b1);
        wr(ADR_GUARD, 16'h2710, 1'b0, 1'b0);
        wr(ADR_GUARD, 16'h0003, 1'b0, 1'b0);
        n = 0;
        while (comm_fault !== 1'b1 && n < 40) begin
            @(negedge sys_clk);
            n++;
        end
        chkb(n >= 18 && n <= 31, 1'b1, "supervision time");
        rd(ADR_GUARD, 16'h0003, 1'b0);
        chkb(comm_fault, 1'b0, "fault cleared");
        wr(ADR_GUARD, 16'h0000, 1'b0, 1'b0);
        repeat (50) @(negedge sys_clk);
        chkb(comm_fault, 1'b0, "supervision off");
        $display("supervision test done");
    endtask

    task automatic t_ack();
        int low;
        move(3'h7, 3, low);
        chk(16'(low), 16'h0004, "zero minimum");
        power_stage_en = 1'b1;
        wr(ADR_ACK_MIN, 16'h0002, 1'b0, 1'b1);
        rd(ADR_ACK_MIN, 16'h0000, 1'b0);
        power_stage_en = 1'b0;
        wr(ADR_ACK_MIN, 16'h4000, 1'b0, 1'b1);
        wr(ADR_ACK_MIN, 16'h3fff, 1'b0, 1'b0);
        wr(ADR_ACK_MIN, 16'h0002, 1'b0, 1'b0);
        move(3'h7, 3, low);
        chkb(low >= 20 && low <= 33, 1'b1, "short move held");
        move(3'h2, 50, low);
        chk(16'(low), 16'h0033, "long move");
        $display("ack test done");
    endtask

    task automatic t_mode();
        wr(ADR_MFC, 16'h0001, 1'b1, 1'b1);
        @(negedge sys_clk);
        mode_fault_code = 16'h5a3c;
        mode_fault_set = 1'b1;
        @(negedge sys_clk);
        mode_fault_set = 1'b0;
        mode_fault_code = 16'ha5c3;
        chkb(mode_fault_flag, 1'b1, "mode flag");
        rd(ADR_MFC, 16'h5a3c, 1'b0);
        chkb(mode_fault_flag, 1'b0, "flag cleared");
        $display("mode fault test done");
    endtask

    // ----------------------------------------
    // clock, watchdog, main sequence
    // ----------------------------------------
    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end

    initial begin
        repeat (16) @(negedge sys_clk);
        arst_n = 1'b1;
        t_reset();
        t_station();
        t_powerup();
        t_order_fw();
        t_guard();
        t_ack();
        t_mode();
        complete_run();
    end
endmodule
`default_nettype wire
